// *** common/scp_pkg.sv ***
// Package for the service-call port trap: constants, types and layouts
package scp_pkg;
  localparam int unsigned NUM_SVC    = 8;
  localparam int unsigned SEG_SHIFT  = 4;
  // Ports above this value need the index port register for addressing
  localparam logic [15:0] DIRECT_MAX = 16'h00ff;
  // Default port of service n is PORT_BASE - n; slot n sits at SLOT_BASE + 4*(n-1)
  localparam logic [15:0] PORT_BASE  = 16'h1008;
  localparam logic [19:0] SLOT_BASE  = 20'h0_0040;
  localparam logic [19:0] SLOT_STEP  = 20'h0_0004;
  localparam logic [2:0]  RST_SVC    = 3'h0;
  localparam logic [1:0]  RST_BYTE   = 2'h0;
  localparam logic [1:0]  LAST_BYTE  = 2'h3;
  localparam logic [15:0] RST_SEG    = 16'h0000;

  typedef enum logic [1:0] {
    SCP_SEG_CODE  = 2'b00,
    SCP_SEG_DATA  = 2'b01,
    SCP_SEG_STACK = 2'b10,
    SCP_SEG_EXTRA = 2'b11
  } scp_seg_e;

  typedef enum logic [1:0] {
    SCP_IDLE  = 2'b00,
    SCP_FETCH = 2'b01,
    SCP_WAIT  = 2'b10,
    SCP_HAND  = 2'b11
  } scp_state_e;

  // Bus cycle seen from the core
  typedef struct packed {
    logic        valid;
    logic        io;
    logic        write;
    logic [15:0] addr;
  } scp_cyc_s;

  // Host reconfiguration write of one service entry
  typedef struct packed {
    logic        valid;
    logic [2:0]  svc;
    logic [15:0] port;
    logic [19:0] slot;
  } scp_cfg_s;

  // Request handed to the host
  typedef struct packed {
    logic        valid;
    logic [2:0]  svc;
    logic [19:0] request_block;
  } scp_req_s;
endpackage : scp_pkg

// *** hw/scp_cfg_mem.sv ***
// Table of service port values and pointer slot addresses, host reconfigurable
`timescale 1ns/100ps
`default_nettype none
module scp_cfg_mem (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  // Host reconfiguration
  input  wire scp_pkg::scp_cfg_s cfg,
  // Lookup
  input  wire logic [2:0]      rd_svc,
  output logic [19:0]          rd_slot,
  output logic [scp_pkg::NUM_SVC*16-1:0] port_vec
);
  logic [15:0] port      [scp_pkg::NUM_SVC];
  logic [19:0] slot      [scp_pkg::NUM_SVC];
  logic [15:0] next_port [scp_pkg::NUM_SVC];
  logic [19:0] next_slot [scp_pkg::NUM_SVC];
  logic [19:0] next_rd_slot;

  for (genvar i = 0; i < scp_pkg::NUM_SVC; i++) begin : g_ent
    // Entry i serves service i+1; entry 7 takes port 1000 and slot 5C
    localparam logic [15:0] DEF_PORT = scp_pkg::PORT_BASE - 16'(i + 1);
    localparam logic [19:0] DEF_SLOT = scp_pkg::SLOT_BASE + 20'(i) * scp_pkg::SLOT_STEP;
    always_comb begin
      next_port[i] = port[i];
      next_slot[i] = slot[i];
      if (cfg.valid && cfg.svc == 3'(i)) begin
        next_port[i] = cfg.port;
        next_slot[i] = cfg.slot;
      end
    end
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        port[i] <= DEF_PORT;
        slot[i] <= DEF_SLOT;
      end else begin
        port[i] <= next_port[i];
        slot[i] <= next_slot[i];
      end
    end
    assign port_vec[i*16 +: 16] = port[i];
  end

  always_comb begin
    next_rd_slot = slot[rd_svc];
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_slot <= '0;
    end else begin
      rd_slot <= next_rd_slot;
    end
  end
endmodule : scp_cfg_mem
`default_nettype wire

// *** hw/scp_trap.sv ***
// Service-call port trap with segment address forming and DMA write stall
`timescale 1ns/100ps
`default_nettype none
module scp_trap (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Core bus cycle and mode
  input  wire scp_pkg::scp_cyc_s cyc,
  input  wire logic [1:0]        emu_mode,
  // Segment address forming
  input  wire logic [1:0]        seg_sel,
  input  wire logic              seg_we,
  input  wire logic [15:0]       seg_wdata,
  input  wire logic [15:0]       offset,
  output logic [19:0]            phys_addr,
  // DMA stall
  input  wire logic              dma_active,
  input  wire logic              instr_mem_write,
  output logic                   exec_stall,
  // Pointer slot reads (program memory)
  output logic                   ptr_rd,
  output logic [19:0]            ptr_addr,
  input  wire logic              ptr_valid,
  input  wire logic [7:0]        ptr_data,
  // Host reconfiguration and request
  input  wire scp_pkg::scp_cfg_s cfg,
  output scp_pkg::scp_req_s      req,
  input  wire logic              req_ack,
  output logic                   trap_hold
);
  logic [scp_pkg::NUM_SVC*16-1:0] port_vec;
  logic [19:0] slot_addr;
  logic [15:0] seg      [4];
  logic [15:0] next_seg [4];
  logic [15:0] seg_cur;
  logic        hit;
  logic [2:0]  hit_svc;
  logic [2:0]  look_svc;
  scp_pkg::scp_state_e state, next_state;
  logic [2:0]  svc, next_svc;

  scp_cfg_mem u_cfg (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .cfg      (cfg),
    .rd_svc   (look_svc),
    .rd_slot  (slot_addr),
    .port_vec (port_vec)
  );

  // Slot lookup follows the latched service once busy, else later bytes hit entry 0
  always_comb begin
    look_svc = (state == scp_pkg::SCP_IDLE) ? hit_svc : svc;
  end

  // Port match; emulation mode plays no part in detection
  always_comb begin
    hit     = 1'b0;
    hit_svc = scp_pkg::RST_SVC;
    for (int i = 0; i < scp_pkg::NUM_SVC; i++) begin
      if (cyc.valid && cyc.io && cyc.write &&
          cyc.addr == port_vec[i*16 +: 16]) begin
        hit     = 1'b1;
        hit_svc = 3'(i);
      end
    end
  end

  // Segment registers
  for (genvar s = 0; s < 4; s++) begin : g_seg
    always_comb begin
      next_seg[s] = seg[s];
      if (seg_we && seg_sel == 2'(s)) begin
        next_seg[s] = seg_wdata;
      end
    end
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        seg[s] <= scp_pkg::RST_SEG;
      end else begin
        seg[s] <= next_seg[s];
      end
    end
  end

  always_comb begin
    seg_cur = seg[seg_sel];
  end

  logic [19:0] next_phys;
  logic        next_stall;
  always_comb begin
    next_phys  = {seg[seg_sel], 4'h0} + {4'h0, offset};
    next_stall = dma_active && instr_mem_write;
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phys_addr  <= '0;
      exec_stall <= 1'b0;
    end else begin
      phys_addr  <= next_phys;
      exec_stall <= next_stall;
    end
  end

  // Trap sequencer: latch, fetch four pointer bytes, hand to host
  logic        next_trap_hold;
  logic [1:0]  bidx, next_bidx;
  logic [19:0] ptr, next_ptr;
  logic [19:0] next_ptr_addr;
  logic        next_ptr_rd;
  scp_pkg::scp_req_s next_req;

  always_comb begin
    next_state    = state;
    next_svc      = svc;
    next_bidx     = bidx;
    next_ptr      = ptr;
    next_ptr_rd   = 1'b0;
    next_ptr_addr = ptr_addr;
    next_req      = req;
    unique case (state)
      scp_pkg::SCP_IDLE: begin
        if (hit) begin
          next_svc   = hit_svc;
          next_bidx  = scp_pkg::RST_BYTE;
          next_state = scp_pkg::SCP_FETCH;
        end
      end
      scp_pkg::SCP_FETCH: begin
        next_ptr_rd   = 1'b1;
        next_ptr_addr = slot_addr + {18'h0_0000, bidx};
        next_state    = scp_pkg::SCP_WAIT;
      end
      scp_pkg::SCP_WAIT: begin
        if (ptr_valid) begin
          // Byte 0 unused, then bits 19:16, 15:8, 7:0 of the 20-bit pointer
          unique case (bidx)
            2'h1:    next_ptr[19:16] = ptr_data[3:0];
            2'h2:    next_ptr[15:8]  = ptr_data;
            2'h3:    next_ptr[7:0]   = ptr_data;
            default: next_ptr        = ptr;
          endcase
          if (bidx == scp_pkg::LAST_BYTE) begin
            next_state = scp_pkg::SCP_HAND;
          end else begin
            next_bidx  = bidx + 2'h1;
            next_state = scp_pkg::SCP_FETCH;
          end
        end else begin
          next_ptr_rd = 1'b1;
        end
      end
      scp_pkg::SCP_HAND: begin
        next_req.valid         = 1'b1;
        next_req.svc           = svc + 3'h1;
        next_req.request_block = ptr;
        if (req_ack && req.valid) begin
          next_req.valid = 1'b0;
          next_state     = scp_pkg::SCP_IDLE;
        end
      end
    endcase
    // Holds the core from the trap until the host ack returns the sequencer to idle
    next_trap_hold = (next_state != scp_pkg::SCP_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state     <= scp_pkg::SCP_IDLE;
      svc       <= scp_pkg::RST_SVC;
      bidx      <= scp_pkg::RST_BYTE;
      ptr       <= '0;
      ptr_rd    <= 1'b0;
      ptr_addr  <= '0;
      req       <= '0;
      trap_hold <= 1'b0;
    end else begin
      state     <= next_state;
      svc       <= next_svc;
      bidx      <= next_bidx;
      ptr       <= next_ptr;
      ptr_rd    <= next_ptr_rd;
      ptr_addr  <= next_ptr_addr;
      req       <= next_req;
      trap_hold <= next_trap_hold;
    end
  end

  // Assertions
  io_read_ignored_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == scp_pkg::SCP_IDLE && !(cyc.io && cyc.write)) |=> state == scp_pkg::SCP_IDLE)
    else $error("Trap started without an I/O write");
  sequence s_hit;
    state == scp_pkg::SCP_IDLE && hit;
  endsequence
  sequence s_first_rd;
    ##2 ptr_rd && ptr_addr == $past(slot_addr);
  endsequence
  slot_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_hit |-> s_first_rd)
    else $error("Pointer slot not read after trap");
  stall_dma_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dma_active && instr_mem_write) |=> exec_stall)
    else $error("Memory write not stalled during DMA");
  no_stall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !dma_active |=> !exec_stall)
    else $error("Stall without DMA");
  phys_form_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !seg_we |=> phys_addr == 20'({$past(seg_cur), 4'h0} + {4'h0, $past(offset)}))
    else $error("Physical address misformed");
  req_svc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(req.valid) |-> req.svc == svc + 3'h1)
    else $error("Service number wrong");
  req_held_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (req.valid && !req_ack) |=> req.valid && $stable(req.request_block))
    else $error("Request dropped before ack");
  trap_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_hit |=> trap_hold [*2])
    else $error("Core not held after trap");
  mode_free_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == scp_pkg::SCP_IDLE && cyc.valid && cyc.io && cyc.write && hit) |=>
      state == scp_pkg::SCP_FETCH)
    else $error("Trap missed in some mode");
endmodule : scp_trap
`default_nettype wire

// *** testbench/scp_prog_mem.sv ***
// Program memory model answering pointer byte reads
`timescale 1ns/100ps
`default_nettype none
module scp_prog_mem (
  // Clock and read port
  input  wire logic        clk_sys,
  input  wire logic        ptr_rd,
  input  wire logic [19:0] ptr_addr,
  input  wire logic [3:0]  lag,
  output logic             ptr_valid,
  output logic [7:0]       ptr_data
);
  logic [19:0] done_addr;
  logic [3:0]  cnt;

  function automatic logic [7:0] byte_at(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : byte_at

  initial begin
    ptr_valid = 1'b0;
    ptr_data  = 8'h00;
    done_addr = 20'hf_ffff;
    cnt       = 4'h0;
  end

  // Slots live here in program memory; data toggles whenever not valid
  always @(posedge clk_sys) begin
    ptr_valid <= 1'b0;
    ptr_data  <= ~ptr_data;
    if (!ptr_rd) begin
      done_addr <= 20'hf_ffff;
      cnt       <= 4'h0;
    end else if (ptr_addr != done_addr && !ptr_valid) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lag) begin
        ptr_valid <= 1'b1;
        ptr_data  <= byte_at(ptr_addr);
        done_addr <= ptr_addr;
        cnt       <= 4'h0;
      end
    end
  end
endmodule : scp_prog_mem
`default_nettype wire

// *** testbench/tb.sv ***
// Testbench for the service-call port trap
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  scp_pkg::scp_cyc_s cyc = '0;
  logic [1:0]        emu_mode = 2'h0;
  logic [1:0]        seg_sel = 2'h0;
  logic              seg_we = 1'b0;
  logic [15:0]       seg_wdata = 16'h0000;
  logic [15:0]       offset = 16'h0000;
  logic [19:0]       phys_addr;
  logic              dma_active = 1'b0;
  logic              instr_mem_write = 1'b0;
  logic              exec_stall;
  logic              ptr_rd;
  logic [19:0]       ptr_addr;
  logic              ptr_valid;
  logic [7:0]        ptr_data;
  scp_pkg::scp_cfg_s cfg = '0;
  scp_pkg::scp_req_s req;
  logic              req_ack = 1'b0;
  logic              trap_hold;
  logic [3:0]        lag = 4'h0;
  int                error_cnt = 0;
  int                check_count = 0;

  always #5 clk_sys = ~clk_sys;

  scp_trap dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .cyc(cyc), .emu_mode(emu_mode),
    .seg_sel(seg_sel), .seg_we(seg_we), .seg_wdata(seg_wdata), .offset(offset),
    .phys_addr(phys_addr), .dma_active(dma_active), .instr_mem_write(instr_mem_write),
    .exec_stall(exec_stall), .ptr_rd(ptr_rd), .ptr_addr(ptr_addr), .ptr_valid(ptr_valid),
    .ptr_data(ptr_data), .cfg(cfg), .req(req), .req_ack(req_ack), .trap_hold(trap_hold));

  scp_prog_mem mem_u (.clk_sys(clk_sys), .ptr_rd(ptr_rd), .ptr_addr(ptr_addr), .lag(lag),
    .ptr_valid(ptr_valid), .ptr_data(ptr_data));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic stop_test;
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic hit(input logic [15:0] port, input logic io, input logic wr);
    cyc = '{valid: 1'b1, io: io, write: wr, addr: port};
    tick(1);
  endtask : hit

  task automatic do_trap(input logic [15:0] port, input logic [2:0] svc, input logic [19:0] slot);
    logic [7:0]  b1;
    logic [19:0] blk;
    int          n;
    b1  = mem_u.byte_at(slot + 20'h0_0001);
    blk = {b1[3:0], mem_u.byte_at(slot + 20'h0_0002), mem_u.byte_at(slot + 20'h0_0003)};
    hit(port, 1'b1, 1'b1);
    cyc = '0;
    tick(1);
    `CHK(trap_hold, 1'b1)
    n = 0;
    while (ptr_rd !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    `CHK(ptr_addr, slot)
    // A second hit while busy must be ignored
    hit(port, 1'b1, 1'b1);
    cyc = '0;
    n = 0;
    while (req.valid !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    `CHK(req.valid, 1'b1)
    `CHK(req.svc, svc)
    `CHK(req.request_block, blk)
    req_ack = 1'b1;
    tick(1);
    req_ack = 1'b0;
    `CHK({req.valid, trap_hold}, 2'b00)
    tick(4);
    `CHK({req.valid, trap_hold, ptr_rd}, 3'b000)
  endtask : do_trap

  task automatic t_defaults;
    for (int i = 0; i < 8; i++) begin
      emu_mode = 2'(i % 3);
      lag = 4'(i);
      do_trap(16'h1008 - 16'(i + 1), 3'(i + 1), 20'h0_0040 + 20'(4 * i));
    end
  endtask : t_defaults

  task automatic t_ignored;
    hit(16'h1007, 1'b0, 1'b1);
    hit(16'h1007, 1'b1, 1'b0);
    hit(16'h1008, 1'b1, 1'b1);
    cyc = '0;
    tick(4);
    `CHK({trap_hold, ptr_rd, req.valid}, 3'b000)
  endtask : t_ignored

  task automatic t_reconfig;
    cfg = '{valid: 1'b1, svc: 3'h2, port: 16'h0123, slot: 20'h8_0200};
    tick(1);
    cfg = '0;
    tick(1);
    lag = 4'h3;
    do_trap(16'h0123, 3'h3, 20'h8_0200);
    hit(16'h1005, 1'b1, 1'b1);
    cyc = '0;
    tick(4);
    `CHK(trap_hold, 1'b0)
  endtask : t_reconfig

  task automatic t_segments;
    logic [15:0] sv;
    for (int s = 0; s < 4; s++) begin
      seg_sel = 2'(s);
      seg_we = 1'b1;
      seg_wdata = 16'hffff - 16'(s) * 16'h4321;
      tick(1);
      seg_we = 1'b0;
    end
    for (int s = 0; s < 4; s++) begin
      sv = 16'hffff - 16'(s) * 16'h4321;
      seg_sel = 2'(s);
      offset = 16'hffff - 16'(s) * 16'h0101;
      tick(1);
      `CHK(phys_addr, 20'({sv, 4'h0} + {4'h0, offset}))
    end
  endtask : t_segments

  task automatic t_dma;
    dma_active = 1'b1;
    tick(2);
    `CHK(exec_stall, 1'b0)
    instr_mem_write = 1'b1;
    tick(1);
    `CHK(exec_stall, 1'b1)
    dma_active = 1'b0;
    tick(1);
    `CHK(exec_stall, 1'b0)
    instr_mem_write = 1'b0;
  endtask : t_dma

  initial begin
    tick(16);
    `CHK({req, trap_hold, ptr_rd, exec_stall, phys_addr}, 47'h0)
    reset_n = 1'b1;
    tick(1);
    t_ignored();
    t_defaults();
    t_reconfig();
    t_segments();
    t_dma();
    stop_test();
  end

  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
